// ==== apc_pkg.sv ====
// Package for absolute position control: register map, field values, constants.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package apc_pkg;
	localparam int APC_SLOTS = 8;
	localparam int APC_MENU = 12;
	localparam logic [7:0] APC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] APC_ADDR_STAT = 8'h04;
	localparam logic [7:0] APC_ADDR_POS = 8'h08;
	localparam logic [7:0] APC_ADDR_DEV = 8'h0c;
	localparam logic [7:0] APC_ADDR_FWD = 8'h10;
	localparam logic [7:0] APC_ADDR_CMD = 8'h14;
	localparam logic [7:0] APC_ADDR_ERR = 8'h18;
	localparam logic [7:0] APC_ADDR_TGT = 8'h20;
	localparam logic [7:0] APC_ADDR_MENU = 8'h40;
	localparam logic [7:0] APC_CURVE_V2 = 8'h02;
	localparam logic [7:0] APC_PULSE_ABS = 8'h02;
	localparam logic [7:0] APC_PULSE_HIRES = 8'h03;
	localparam logic [7:0] APC_RST_TRIP_ONLY = 8'h03;
	localparam logic [7:0] APC_GROUP_USER = 8'h02;
	localparam logic [7:0] APC_FN_SPD = 8'h49;
	localparam logic [7:0] APC_FN_ORT = 8'h2d;
	localparam logic [31:0] APC_FWD_MAX = 32'h0fffffff;
	localparam logic [31:0] APC_FWD_RESET = 32'h0fffffff;
	localparam logic [15:0] APC_ERR_RANGE = 16'h0072;
	localparam logic [15:0] APC_MENU_OFF = 16'h0000;
	localparam logic [7:0] APC_TEACH_RESET = 8'h00;
	localparam int APC_BLINK_NS = 500000000;
	localparam int APC_CLK_NS = 10;
	localparam int APC_BLINK_CYC = APC_BLINK_NS / APC_CLK_NS;
	typedef enum logic [2:0] {APC_IDLE, APC_ZERO, APC_MOVE, APC_LOCK} apc_state_e;
	typedef struct packed {
		logic fwd;
		logic rev;
		logic run;
		logic [5:0] spare;
	} apc_drive_s;
endpackage : apc_pkg

// ==== apc_top.sv ====
// Absolute position control logic with an AXI4-Lite register file.
// Assumes feedback pulses and terminals arrive synchronous to i_clk_sys.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module apc_top
	import apc_pkg::*;
#(
	parameter int BLINK_CYC = APC_BLINK_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_reset_terminal,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	input wire logic [7:0] i_term_func,
	input wire logic i_term_level,
	input wire logic i_run_cmd,
	input wire logic i_dir_cmd,
	input wire logic [2:0] i_stage_sel,
	input wire logic i_position_clear_input,
	input wire logic i_torque_control_enable_input,
	input wire logic i_pulse_train_enable_input,
	input wire logic i_home_search_req,
	input wire logic i_store_key,
	input wire logic i_at_speed,
	input wire logic [31:0] i_decel_dist,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output apc_drive_s o_drive,
	output logic o_decel,
	output logic o_pos_done,
	output logic o_home_search_en,
	output logic o_torque_en,
	output logic o_pulse_train_en,
	output logic o_programming_indicator,
	output logic [15:0] o_display,
	output logic o_user_group_only
);
	// Control register fields
	logic [7:0] curve_selection_first_motor;
	logic [7:0] control_pulse_setting;
	logic [7:0] reset_behaviour_select;
	logic [7:0] display_group_select;
	logic [7:0] teach_slot_select;
	logic [1:0] zero_mode;
	logic [31:0] forward_range_limit;
	logic [31:0] target [APC_SLOTS];
	logic [15:0] user_menu_slot [APC_MENU];
	logic signed [31:0] pos;
	logic signed [31:0] dev;
	logic [15:0] error_code_monitor;
	logic zero_req;
	apc_state_e state;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [1:0] enc_q;
	logic [31:0] blink_cnt;
	logic reset_q, store_q;
	// Terminal decode
	logic abs_mode, hires, pos_sel, teach_input, speed_position_select_input;
	logic auto_position_mode, wr_fire;
	logic signed [31:0] tgt, diff, abs_diff, next_pos;
	logic [1:0] enc_now;
	always_comb begin
		abs_mode = (curve_selection_first_motor == APC_CURVE_V2) &&
			(control_pulse_setting == APC_PULSE_ABS || control_pulse_setting == APC_PULSE_HIRES);
		hires = control_pulse_setting == APC_PULSE_HIRES;
		speed_position_select_input = (i_term_func == APC_FN_SPD) && i_term_level;
		pos_sel = (i_term_func != APC_FN_SPD) || speed_position_select_input;
		auto_position_mode = abs_mode && pos_sel;
		teach_input = (i_term_func == APC_FN_ORT) && i_term_level &&
			(control_pulse_setting == APC_PULSE_ABS || control_pulse_setting == APC_PULSE_HIRES);
		tgt = $signed(target[i_stage_sel]);
		diff = tgt - pos;
		abs_diff = diff[31] ? -diff : diff;
		wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	end
	// Quadrature decode: x1 normally, x4 at high resolution
	always_comb begin
		enc_now = {i_enc_a, i_enc_b};
		next_pos = pos;
		if (enc_now != enc_q) begin
			case ({enc_q, enc_now})
				4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
					if (hires || enc_now == 2'b01)
						next_pos = pos + 32'sd1;
				end
				4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
					if (hires || enc_now == 2'b10)
						next_pos = pos - 32'sd1;
				end
				default: next_pos = pos;
			endcase
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			enc_q <= {i_enc_a, i_enc_b};
		else
			enc_q <= enc_now;
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			reset_q <= 1'b0;
			store_q <= 1'b0;
		end else begin
			reset_q <= i_reset_terminal;
			store_q <= i_store_key;
		end
	end
	// Current position counter
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			pos <= '0;
		else if (i_position_clear_input)
			pos <= '0;
		else if (i_reset_terminal && !reset_q && reset_behaviour_select != APC_RST_TRIP_ONLY)
			pos <= '0;
		else
			pos <= next_pos;
	end
	// Deviation counter
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_position_clear_input)
			dev <= '0;
		else if (state == APC_MOVE || state == APC_LOCK)
			dev <= diff;
		else
			dev <= '0;
	end
	// Motion sequencer
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state <= APC_IDLE;
			o_drive <= '0;
			o_decel <= 1'b0;
			o_pos_done <= 1'b0;
		end else begin
			case (state)
				APC_IDLE: begin
					o_drive <= '0;
					o_decel <= 1'b0;
					if (i_run_cmd && auto_position_mode && zero_req)
						state <= APC_ZERO;
					else if (i_run_cmd && auto_position_mode) begin
						if (diff == 0) begin
							o_pos_done <= 1'b1;
							state <= APC_LOCK;
						end else begin
							o_pos_done <= 1'b0;
							state <= APC_MOVE;
						end
					end
				end
				APC_ZERO: begin
					o_drive.run <= 1'b1;
					o_drive.rev <= pos > 0;
					o_drive.fwd <= pos < 0;
					o_decel <= zero_mode == 2'd0;
					if (!i_run_cmd)
						state <= APC_IDLE;
					else if (pos == 0)
						state <= APC_LOCK;
				end
				APC_MOVE: begin
					o_drive.run <= 1'b1;
					o_drive.fwd <= !diff[31];
					o_drive.rev <= diff[31];
					o_decel <= $unsigned(abs_diff) <= i_decel_dist && !i_at_speed || $unsigned(abs_diff) <= i_decel_dist;
					if (!i_run_cmd)
						state <= APC_IDLE;
					else if (diff == 0) begin
						o_pos_done <= 1'b1;
						state <= APC_LOCK;
					end
				end
				APC_LOCK: begin
					o_drive.run <= 1'b1;
					o_drive.fwd <= 1'b0;
					o_drive.rev <= 1'b0;
					o_decel <= 1'b0;
					if (!i_run_cmd) begin
						o_drive <= '0;
						state <= APC_IDLE;
					end
				end
				default: state <= APC_IDLE;
			endcase
		end
	end
	// Blocked functions in position mode
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_home_search_en <= 1'b0;
			o_torque_en <= 1'b0;
			o_pulse_train_en <= 1'b0;
		end else begin
			o_home_search_en <= i_home_search_req && !abs_mode && state != APC_ZERO;
			o_torque_en <= i_torque_control_enable_input && !abs_mode;
			o_pulse_train_en <= i_pulse_train_enable_input && !abs_mode;
		end
	end
	// Parameter conflict check and indicator flash
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			error_code_monitor <= '0;
			blink_cnt <= '0;
			o_programming_indicator <= 1'b0;
		end else begin
			error_code_monitor <= (forward_range_limit > APC_FWD_MAX) ? APC_ERR_RANGE : '0;
			if (error_code_monitor == '0) begin
				blink_cnt <= '0;
				o_programming_indicator <= 1'b0;
			end else if (blink_cnt >= BLINK_CYC - 1) begin
				blink_cnt <= '0;
				o_programming_indicator <= !o_programming_indicator;
			end else
				blink_cnt <= blink_cnt + 32'd1;
		end
	end
	// Display: four top hex digits when value is long
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_display <= '0;
			o_user_group_only <= 1'b0;
		end else begin
			o_user_group_only <= display_group_select == APC_GROUP_USER;
			if (error_code_monitor != '0)
				o_display <= error_code_monitor;
			else if (pos[31:16] != '0)
				o_display <= pos[31:16];
			else
				o_display <= pos[15:0];
		end
	end
	// AXI4-Lite write path
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr < APC_ADDR_MENU + 8'd48) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_comb begin
		s_axi_awready = !aw_hold && !s_axi_bvalid;
		s_axi_wready = !w_hold && !s_axi_bvalid;
	end
	// Register storage
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			curve_selection_first_motor <= '0;
			control_pulse_setting <= '0;
			reset_behaviour_select <= '0;
			display_group_select <= '0;
			teach_slot_select <= APC_TEACH_RESET;
			zero_mode <= '0;
			zero_req <= 1'b0;
			forward_range_limit <= APC_FWD_RESET;
			for (int i = 0; i < APC_SLOTS; i++)
				target[i] <= '0;
			for (int i = 0; i < APC_MENU; i++)
				user_menu_slot[i] <= APC_MENU_OFF;
		end else begin
			if (state == APC_ZERO && pos == 0)
				zero_req <= 1'b0;
			if (i_store_key && !store_q)
				target[teach_slot_select[2:0]] <= pos;
			if (wr_fire && w_strb == 4'hf) begin
				case (aw_addr)
					APC_ADDR_CTRL: begin
						curve_selection_first_motor <= w_data[7:0];
						control_pulse_setting <= w_data[15:8];
						reset_behaviour_select <= w_data[23:16];
						display_group_select <= w_data[31:24];
					end
					APC_ADDR_CMD: begin
						teach_slot_select <= {5'd0, w_data[2:0]};
						zero_mode <= (w_data[9:8] == 2'd3) ? 2'd2 : w_data[9:8];
						if (w_data[12])
							zero_req <= 1'b1;
					end
					APC_ADDR_FWD: begin
						if (w_data <= APC_FWD_MAX || hires)
							forward_range_limit <= w_data;
					end
					default: begin
						if (aw_addr >= APC_ADDR_TGT && aw_addr < APC_ADDR_MENU)
							target[aw_addr[4:2]] <= w_data;
						else if (aw_addr >= APC_ADDR_MENU && aw_addr < APC_ADDR_MENU + 8'd48)
							user_menu_slot[4'((aw_addr - APC_ADDR_MENU) >> 2)] <= w_data[15:0];
					end
				endcase
			end
		end
	end
	// AXI4-Lite read path
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr[7:0])
				APC_ADDR_CTRL: s_axi_rdata <= {display_group_select, reset_behaviour_select,
					control_pulse_setting, curve_selection_first_motor};
				APC_ADDR_STAT: s_axi_rdata <= {24'd0, 1'(zero_req), 1'(auto_position_mode),
					1'(teach_input), 1'(o_pos_done), 1'b0, 3'(state)};
				APC_ADDR_POS: s_axi_rdata <= pos;
				APC_ADDR_DEV: s_axi_rdata <= dev;
				APC_ADDR_FWD: s_axi_rdata <= forward_range_limit;
				APC_ADDR_CMD: s_axi_rdata <= {22'd0, zero_mode, teach_slot_select};
				APC_ADDR_ERR: s_axi_rdata <= {16'd0, error_code_monitor};
				default: begin
					if (s_axi_araddr[7:0] >= APC_ADDR_TGT && s_axi_araddr[7:0] < APC_ADDR_MENU)
						s_axi_rdata <= target[s_axi_araddr[4:2]];
					else if (s_axi_araddr[7:0] >= APC_ADDR_MENU && s_axi_araddr[7:0] < 8'h70)
						s_axi_rdata <= {16'd0, user_menu_slot[4'((s_axi_araddr[7:0] - APC_ADDR_MENU) >> 2)]};
					else begin
						s_axi_rdata <= '0;
						s_axi_rresp <= 2'b10;
					end
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	always_comb s_axi_arready = !s_axi_rvalid;

	pos_done_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state == APC_MOVE && i_run_cmd && diff == 0) |=> o_pos_done && state == APC_LOCK)
		else $error("Arrival did not lock");
	clear_pos_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_position_clear_input |=> pos == 0 && dev == 0)
		else $error("Position clear failed");
	torque_off_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		abs_mode |=> !o_torque_en && !o_pulse_train_en)
		else $error("Torque input not ignored");
	home_block_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		state == APC_ZERO |=> !o_home_search_en)
		else $error("Home search during zero return");
	dir_sign_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state == APC_MOVE && $past(state) == APC_MOVE && o_drive.fwd) |-> !o_drive.rev)
		else $error("Both directions driven");
	zero_done_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state == APC_IDLE && i_run_cmd && auto_position_mode && !zero_req && diff == 0)
		|=> o_pos_done && !o_drive.fwd && !o_drive.rev)
		else $error("Zero target moved motor");
	reset_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_reset_terminal && !reset_q && reset_behaviour_select != APC_RST_TRIP_ONLY)
		|=> pos == 0)
		else $error("Reset terminal did not clear");
	store_slot_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_store_key && !store_q && !wr_fire) |=> target[$past(teach_slot_select[2:0])] == $past(pos))
		else $error("Teach store wrong");
	err_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(error_code_monitor == 0) |=> !o_programming_indicator)
		else $error("Indicator flashing without error");
	user_grp_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(display_group_select == APC_GROUP_USER) |=> o_user_group_only)
		else $error("User group not selected");
endmodule : apc_top

// ==== apc_motor_model.sv ====
// Motor and quadrature feedback model facing the position control block.
// Assumes the drive struct and the testbench move request share i_clk_sys.
`timescale 1ns/1ps
module apc_motor_model
	import apc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire apc_drive_s i_drive,
	input wire logic i_ext_step,
	input wire logic i_ext_dir,
	output logic o_enc_a,
	output logic o_enc_b,
	output logic o_at_speed
);
	logic [1:0] div = 2'd0;
	logic [1:0] phase = 2'd0;
	logic moving;
	logic dir_fwd;
	// Outside push wins over the drive
	assign moving = i_ext_step || (i_drive.run && (i_drive.fwd != i_drive.rev));
	assign dir_fwd = i_ext_step ? i_ext_dir : i_drive.fwd;
	// One quarter step every four clocks while moving
	always_ff @(posedge i_clk_sys) begin
		div <= moving ? div + 2'd1 : 2'd0;
		o_at_speed <= moving;
		if (moving && div == 2'd3) begin
			phase <= dir_fwd ? phase + 2'd1 : phase - 2'd1;
		end
	end
	// Forward gray order 00, 01, 11, 10
	assign o_enc_a = phase[1];
	assign o_enc_b = phase[1] ^ phase[0];
endmodule : apc_motor_model

// ==== tb_top.sv ====
// Self-checking testbench for the absolute position control block.
// Assumes the motor model file and the design package are compiled first.
`timescale 1ns/1ps
module tb_top
	import apc_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_reset_terminal = 1'b0;
	logic i_enc_a, i_enc_b, i_at_speed;
	logic [7:0] i_term_func = 8'h00;
	logic i_term_level = 1'b0;
	logic i_run_cmd = 1'b0;
	logic i_dir_cmd = 1'b0;
	logic [2:0] i_stage_sel = 3'h0;
	logic i_position_clear_input = 1'b0;
	logic i_torque_control_enable_input = 1'b1;
	logic i_pulse_train_enable_input = 1'b1;
	logic i_home_search_req = 1'b1;
	logic i_store_key = 1'b0;
	logic [31:0] i_decel_dist = 32'h00000002;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	apc_drive_s o_drive;
	logic o_decel, o_pos_done, o_home_search_en, o_torque_en, o_pulse_train_en;
	logic o_programming_indicator, o_user_group_only;
	logic [15:0] o_display;
	logic ext_step = 1'b0;
	logic ext_dir = 1'b0;
	logic [31:0] rv;
	logic v;
	logic seen;
	int fail_count = 0;
	int check_count = 0;
	logic [7:0] row_a [9] = '{APC_ADDR_CTRL, APC_ADDR_CMD, APC_ADDR_FWD, APC_ADDR_POS,
		APC_ADDR_DEV, APC_ADDR_ERR, APC_ADDR_TGT, APC_ADDR_MENU, 8'h80};
	logic [31:0] row_d [9] = '{32'h0, 32'h0, APC_FWD_RESET, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0};
	logic [1:0] row_r [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

	apc_top #(.BLINK_CYC(4)) uut (.i_clk_sys, .i_sys_rst, .i_reset_terminal, .i_enc_a,
		.i_enc_b, .i_term_func, .i_term_level, .i_run_cmd, .i_dir_cmd, .i_stage_sel,
		.i_position_clear_input, .i_torque_control_enable_input, .i_pulse_train_enable_input,
		.i_home_search_req, .i_store_key, .i_at_speed, .i_decel_dist, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .o_drive, .o_decel, .o_pos_done, .o_home_search_en, .o_torque_en,
		.o_pulse_train_en, .o_programming_indicator, .o_display, .o_user_group_only);

	apc_motor_model motor (.i_clk_sys, .i_drive(o_drive), .i_ext_step(ext_step),
		.i_ext_dir(ext_dir), .o_enc_a(i_enc_a), .o_enc_b(i_enc_b), .o_at_speed(i_at_speed));

	initial begin
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	task automatic give_verdict;
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge i_clk_sys);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge i_clk_sys); while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do @(posedge i_clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge i_clk_sys); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(rv & m, e);
	endtask : rdchk

	task automatic ext_move(input logic dir, input int q);
		ext_dir <= dir;
		ext_step <= 1'b1;
		repeat (q * 4) @(posedge i_clk_sys);
		ext_step <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
	endtask : ext_move

	task automatic pulse_clear;
		i_position_clear_input <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_position_clear_input <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
	endtask : pulse_clear

	task automatic pulse_rst_term;
		i_reset_terminal <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_reset_terminal <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
	endtask : pulse_rst_term

	task automatic run_to(input logic [2:0] st, input logic dir);
		int n;
		n = 0;
		seen = 1'b0;
		i_stage_sel <= st;
		i_dir_cmd <= dir;
		i_run_cmd <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		while (o_pos_done !== 1'b1 && n < 3000) begin
			@(posedge i_clk_sys);
			n++;
			if (o_decel === 1'b1)
				seen = 1'b1;
		end
		chk({31'h0, o_pos_done}, 32'h1);
		i_run_cmd <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask : run_to

	initial begin
		repeat (60000) @(posedge i_clk_sys);
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		for (int i = 0; i < 9; i++) begin
			rd(row_a[i]);
			chk({30'h0, rr}, {30'h0, row_r[i]});
			chk((row_r[i] == 2'h0) ? rv : 32'h0, row_d[i]);
		end
		for (int i = 0; i < APC_MENU; i++) begin
			wr(APC_ADDR_MENU + 8'(4 * i), 32'(i + 1));
			chk({30'h0, br}, 32'h0);
			rdchk(APC_ADDR_MENU + 8'(4 * i), 32'hffff, 32'(i + 1));
		end
		wr(8'h70, 32'h1);
		chk({30'h0, br}, 32'h2);
		wr(APC_ADDR_CTRL, 32'h00000102);
		rdchk(APC_ADDR_STAT, 32'h40, 32'h0);
		chk({31'h0, o_torque_en}, 32'h1);
		wr(APC_ADDR_CTRL, 32'h00000201);
		rdchk(APC_ADDR_STAT, 32'h40, 32'h0);
		wr(APC_ADDR_CTRL, 32'h00000202);
		rdchk(APC_ADDR_STAT, 32'h40, 32'h40);
		chk({29'h0, o_torque_en, o_pulse_train_en, o_home_search_en}, 32'h0);
		i_term_func <= APC_FN_SPD;
		repeat (3) @(posedge i_clk_sys);
		rdchk(APC_ADDR_STAT, 32'h40, 32'h0);
		i_term_level <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		rdchk(APC_ADDR_STAT, 32'h40, 32'h40);
		i_term_func <= APC_FN_ORT;
		repeat (3) @(posedge i_clk_sys);
		rdchk(APC_ADDR_STAT, 32'h20, 32'h20);
		wr(APC_ADDR_CTRL, 32'h02000202);
		@(posedge i_clk_sys);
		chk({31'h0, o_user_group_only}, 32'h1);
		wr(APC_ADDR_CTRL, 32'h00000202);
		@(posedge i_clk_sys);
		chk({31'h0, o_user_group_only}, 32'h0);
		ext_move(1'b1, 8);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h2);
		pulse_rst_term();
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h0);
		ext_move(1'b1, 4);
		wr(APC_ADDR_CTRL, 32'h00030202);
		pulse_rst_term();
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h1);
		pulse_clear();
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h0);
		rdchk(APC_ADDR_DEV, 32'hffffffff, 32'h0);
		ext_move(1'b0, 1);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'hffffffff);
		chk({16'h0, o_display}, 32'hffff);
		wr(APC_ADDR_CTRL, 32'h00000302);
		pulse_clear();
		ext_move(1'b1, 4);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h4);
		wr(APC_ADDR_CTRL, 32'h00000202);
		wr(APC_ADDR_TGT + 8'h04, 32'h8);
		wr(APC_ADDR_TGT + 8'h08, 32'h3);
		pulse_clear();
		run_to(3'h1, 1'b1);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h8);
		chk({31'h0, seen}, 32'h1);
		run_to(3'h2, 1'b0);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h3);
		wr(APC_ADDR_CMD, 32'h5);
		i_store_key <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_store_key <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		rdchk(APC_ADDR_TGT + 8'h14, 32'hffffffff, 32'h3);
		wr(APC_ADDR_CMD, 32'h1300);
		rdchk(APC_ADDR_CMD, 32'h307, 32'h200);
		i_run_cmd <= 1'b1;
		repeat (100) @(posedge i_clk_sys);
		rdchk(APC_ADDR_STAT, 32'h87, 32'h3);
		chk({31'h0, o_home_search_en}, 32'h0);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h0);
		i_run_cmd <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		pulse_clear();
		run_to(3'h0, 1'b0);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h0);
		wr(APC_ADDR_FWD, 32'h10000000);
		rdchk(APC_ADDR_FWD, 32'hffffffff, APC_FWD_MAX);
		wr(APC_ADDR_FWD, 32'h0);
		rdchk(APC_ADDR_FWD, 32'hffffffff, 32'h0);
		wr(APC_ADDR_CTRL, 32'h00000302);
		wr(APC_ADDR_FWD, 32'h10000000);
		wr(APC_ADDR_CTRL, 32'h00000202);
		rdchk(APC_ADDR_ERR, 32'hffff, {16'h0, APC_ERR_RANGE});
		chk({16'h0, o_display}, {16'h0, APC_ERR_RANGE});
		v = o_programming_indicator;
		repeat (4) @(posedge i_clk_sys);
		chk({31'h0, o_programming_indicator}, {31'h0, ~v});
		wr(APC_ADDR_FWD, APC_FWD_MAX);
		repeat (3) @(posedge i_clk_sys);
		rdchk(APC_ADDR_ERR, 32'hffff, 32'h0);
		chk({31'h0, o_programming_indicator}, 32'h0);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		@(posedge i_clk_sys);
		rdchk(APC_ADDR_CMD, 32'hffffffff, 32'h0);
		rdchk(APC_ADDR_POS, 32'hffffffff, 32'h0);
		give_verdict();
	end
endmodule : tb_top
